// file: rtl/hu_uart.v
// Host UART with flow control, automatic baud divider and APB registers
`timescale 1ns/1ps
`include "hu_uart_map.vh"
`default_nettype none
module hu_uart #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire pclk,
	input wire presetn,
	input wire por_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire host_tx_serial_in,
	input wire host_request_in,
	output reg host_rx_serial_out,
	output reg clear_to_host_out
);
	localparam TX_IDLE = 2'd0;
	localparam TX_START = 2'd1;
	localparam TX_DATA = 2'd2;
	localparam TX_STOP = 2'd3;
	localparam RX_IDLE = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_DATA = 2'd2;
	localparam RX_STOP = 2'd3;
	localparam [31:0] CLK_HZ = `HU_CLK_HZ;
	localparam [31:0] DEF_DIV = `HU_DEF_DIV;

	function is_flow_char;
		input [7:0] c;
		begin
			is_flow_char = (c == `HU_XON) || (c == `HU_XOFF);
		end
	endfunction

	wire rst_n = presetn & por_n;
	wire acc = psel & penable;
	wire done = acc & pready;
	wire wr = done & pwrite;
	wire rd = done & ~pwrite;

	// baud_q and div_q kept over presetn, set to defaults only by por_n
	reg [31:0] baud_q;
	reg [15:0] div_q;
	reg [1:0] ctrl_q;
	reg overrun_q, bad_baud_q, frame_err_q, xoff_rx_q, xoff_sent_q;
	reg calc_busy_q;
	reg [5:0] calc_i_q;
	reg [31:0] den_q, num_q, quo_q;
	reg [32:0] rem_q;
	reg rts_s1_q, rts_s2_q, rxd_s1_q, rxd_s2_q, rxd_s3_q;
	reg [1:0] tx_st_q, rx_st_q;
	reg [15:0] tx_cnt_q, rx_cnt_q;
	reg [2:0] tx_bit_q, rx_bit_q;
	reg [7:0] tx_sh_q, rx_sh_q, rx_byte_q;
	reg rx_stb_q;
	reg [31:0] rdata;
	reg hit;

	wire hw_en = ctrl_q[`HU_CTRL_HW_HS];
	wire sw_en = ctrl_q[`HU_CTRL_SW_FLOW];
	wire [15:0] div_m1 = div_q - 16'h0001;
	wire [15:0] div_half = {1'b0, div_q[15:1]};
	wire [32:0] rem_sh = {rem_q[31:0], num_q[31]};
	wire rem_ge = rem_sh >= {1'b0, den_q};
	wire calc_done = calc_busy_q & (calc_i_q == 6'd0);

	wire tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
	wire [7:0] tx_out_data, rx_out_data;
	wire [FIFO_AW:0] rx_count;

	wire sel_ctrl = (paddr == `HU_OFF_CTRL);
	wire sel_baud = (paddr == `HU_OFF_BAUD);
	wire sel_stat = (paddr == `HU_OFF_STATUS);
	wire sel_tx = (paddr == `HU_OFF_TXDATA);
	wire sel_rx = (paddr == `HU_OFF_RXDATA);
	wire baud_ok = (pwdata >= `HU_MIN_BAUD) && (pwdata <= `HU_MAX_BAUD);
	wire stall = pwrite & ((sel_tx & ~tx_in_ready) | (sel_baud & calc_busy_q));

	wire hs_ok = ~hw_en | rts_s2_q;
	wire paused = sw_en & xoff_rx_q;
	wire need_xoff = sw_en & ~xoff_sent_q & (rx_count >= `HU_RX_HIGH);
	wire need_xon = sw_en & xoff_sent_q & (rx_count <= `HU_RX_LOW);
	wire tx_go = (tx_st_q == TX_IDLE) & ~need_xoff & ~need_xon & tx_out_valid & hs_ok & ~paused;
	wire rx_push = rx_stb_q & ~(sw_en & is_flow_char(rx_byte_q));

	// Read mux and address decode
	always @*
	begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		if (sel_ctrl)
			rdata = {30'h0000_0000, ctrl_q};
		else if (sel_baud)
			rdata = baud_q;
		else if (sel_stat)
		begin
			rdata[`HU_ST_TX_FULL] = ~tx_in_ready;
			rdata[`HU_ST_RX_AVAIL] = rx_out_valid;
			rdata[`HU_ST_BAUD_BUSY] = calc_busy_q;
			rdata[`HU_ST_OVERRUN] = overrun_q;
			rdata[`HU_ST_BAD_BAUD] = bad_baud_q;
			rdata[`HU_ST_FRAME_ERR] = frame_err_q;
			rdata[`HU_ST_TX_PAUSED] = paused;
			rdata[`HU_ST_TX_IDLE] = (tx_st_q == TX_IDLE) & ~tx_out_valid;
			rdata[`HU_ST_HS_ADVISED] = (baud_q > `HU_HS_ADVISE_BAUD) & ~hw_en;
		end
		else if (sel_div_read(paddr))
			rdata = {16'h0000, div_q};
		else if (sel_tx)
			rdata = 32'h0000_0000;
		else if (sel_rx)
			rdata = {24'h00_0000, rx_out_data};
		else
			hit = 1'b0;
	end

	function sel_div_read;
		input [7:0] a;
		begin
			sel_div_read = (a == `HU_OFF_DIV);
		end
	endfunction

	// APB slave, one wait state, longer while stalled
	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (done)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (acc & ~stall)
		begin
			pready <= 1'b1;
			pslverr <= ~hit;
			prdata <= rdata;
		end
	end

	// Power-up defaults, kept across presetn
	always @(posedge pclk or negedge por_n)
	begin
		if (!por_n)
		begin
			baud_q <= `HU_DEF_BAUD;
			div_q <= DEF_DIV[15:0];
		end
		else if (calc_done)
		begin
			baud_q <= den_q;
			div_q <= quo_q[15:0];
		end
	end

	// Control, sticky flags, divider computation
	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= 2'b00;
			overrun_q <= 1'b0;
			bad_baud_q <= 1'b0;
			frame_err_q <= 1'b0;
			xoff_rx_q <= 1'b0;
			calc_busy_q <= 1'b0;
			calc_i_q <= 6'd0;
			den_q <= 32'h0000_0000;
			num_q <= 32'h0000_0000;
			quo_q <= 32'h0000_0000;
			rem_q <= 33'h0_0000_0000;
		end
		else
		begin
			if (wr & sel_ctrl)
				ctrl_q <= pwdata[1:0];
			overrun_q <= (overrun_q & ~(wr & sel_stat & pwdata[`HU_ST_OVERRUN])) | (rx_push & ~rx_in_ready);
			bad_baud_q <= (bad_baud_q & ~(wr & sel_stat & pwdata[`HU_ST_BAD_BAUD])) | (wr & sel_baud & ~baud_ok);
			frame_err_q <= (frame_err_q & ~(wr & sel_stat & pwdata[`HU_ST_FRAME_ERR]))
				| ((rx_st_q == RX_STOP) & (rx_cnt_q == div_m1) & ~rxd_s2_q);
			if (~sw_en)
				xoff_rx_q <= 1'b0;
			else if (rx_stb_q & (rx_byte_q == `HU_XOFF))
				xoff_rx_q <= 1'b1;
			else if (rx_stb_q & (rx_byte_q == `HU_XON))
				xoff_rx_q <= 1'b0;
			if (wr & sel_baud & baud_ok)
			begin
				calc_busy_q <= 1'b1;
				calc_i_q <= 6'd32;
				den_q <= pwdata;
				num_q <= CLK_HZ + {1'b0, pwdata[31:1]};
				quo_q <= 32'h0000_0000;
				rem_q <= 33'h0_0000_0000;
			end
			else if (calc_done)
				calc_busy_q <= 1'b0;
			else if (calc_busy_q)
			begin
				rem_q <= rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
				quo_q <= {quo_q[30:0], rem_ge};
				num_q <= {num_q[30:0], 1'b0};
				calc_i_q <= calc_i_q - 6'd1;
			end
		end
	end

	// Pin synchronisers
	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rts_s1_q <= 1'b0;
			rts_s2_q <= 1'b0;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			rxd_s3_q <= 1'b1;
		end
		else
		begin
			rts_s1_q <= host_request_in;
			rts_s2_q <= rts_s1_q;
			rxd_s1_q <= host_tx_serial_in;
			rxd_s2_q <= rxd_s1_q;
			rxd_s3_q <= rxd_s2_q;
		end
	end

	// Transmitter toward the host
	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 3'd0;
			tx_sh_q <= 8'h00;
			xoff_sent_q <= 1'b0;
			host_rx_serial_out <= 1'b1;
			clear_to_host_out <= 1'b1;
		end
		else
		begin
			clear_to_host_out <= ~hw_en | (rx_count < `HU_RX_HIGH);
			if (~sw_en)
				xoff_sent_q <= 1'b0;
			case (tx_st_q)
				TX_IDLE:
				begin
					tx_cnt_q <= 16'h0000;
					if (need_xoff | need_xon)
					begin
						tx_sh_q <= need_xoff ? `HU_XOFF : `HU_XON;
						xoff_sent_q <= need_xoff;
						host_rx_serial_out <= 1'b0;
						tx_st_q <= TX_START;
					end
					else if (tx_go)
					begin
						tx_sh_q <= tx_out_data;
						host_rx_serial_out <= 1'b0;
						tx_st_q <= TX_START;
					end
				end
				TX_START:
				begin
					tx_cnt_q <= (tx_cnt_q == div_m1) ? 16'h0000 : tx_cnt_q + 16'h0001;
					if (tx_cnt_q == div_m1)
					begin
						host_rx_serial_out <= tx_sh_q[0];
						tx_bit_q <= 3'd0;
						tx_st_q <= TX_DATA;
					end
				end
				TX_DATA:
				begin
					tx_cnt_q <= (tx_cnt_q == div_m1) ? 16'h0000 : tx_cnt_q + 16'h0001;
					if (tx_cnt_q == div_m1)
					begin
						if (tx_bit_q == 3'd7)
						begin
							host_rx_serial_out <= 1'b1;
							tx_st_q <= TX_STOP;
						end
						else
						begin
							host_rx_serial_out <= tx_sh_q[1];
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
							tx_bit_q <= tx_bit_q + 3'd1;
						end
					end
				end
				default:
				begin
					tx_cnt_q <= (tx_cnt_q == div_m1) ? 16'h0000 : tx_cnt_q + 16'h0001;
					if (tx_cnt_q == div_m1)
						tx_st_q <= TX_IDLE;
				end
			endcase
		end
	end

	// Receiver from the host, sampling mid-bit
	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'd0;
			rx_sh_q <= 8'h00;
			rx_byte_q <= 8'h00;
			rx_stb_q <= 1'b0;
		end
		else
		begin
			rx_stb_q <= 1'b0;
			case (rx_st_q)
				RX_IDLE:
				begin
					rx_cnt_q <= 16'h0000;
					if (~rxd_s2_q & rxd_s3_q)
						rx_st_q <= RX_START;
				end
				RX_START:
				begin
					rx_cnt_q <= (rx_cnt_q == div_half) ? 16'h0000 : rx_cnt_q + 16'h0001;
					if (rx_cnt_q == div_half)
					begin
						rx_bit_q <= 3'd0;
						rx_st_q <= rxd_s2_q ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					rx_cnt_q <= (rx_cnt_q == div_m1) ? 16'h0000 : rx_cnt_q + 16'h0001;
					if (rx_cnt_q == div_m1)
					begin
						rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'd1;
						if (rx_bit_q == 3'd7)
							rx_st_q <= RX_STOP;
					end
				end
				default:
				begin
					rx_cnt_q <= (rx_cnt_q == div_m1) ? 16'h0000 : rx_cnt_q + 16'h0001;
					if (rx_cnt_q == div_m1)
					begin
						rx_byte_q <= rx_sh_q;
						rx_stb_q <= rxd_s2_q;
						rx_st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	hu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
		.pclk(pclk),
		.rst_n(rst_n),
		.in_valid(wr & sel_tx),
		.in_ready(tx_in_ready),
		.in_data(pwdata[7:0]),
		.out_valid(tx_out_valid),
		.out_ready(tx_go),
		.out_data(tx_out_data),
		.count()
	);

	hu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
		.pclk(pclk),
		.rst_n(rst_n),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data(rx_byte_q),
		.out_valid(rx_out_valid),
		.out_ready(rd & sel_rx),
		.out_data(rx_out_data),
		.count(rx_count)
	);
endmodule // hu_uart
`default_nettype wire

// file: rtl/hu_uart_map.vh
// Register map, field positions, reset values and timing counts of the host UART
`ifndef HU_UART_MAP_VH
`define HU_UART_MAP_VH

// Register byte offsets
`define HU_OFF_CTRL 8'h00
`define HU_OFF_BAUD 8'h04
`define HU_OFF_DIV 8'h08
`define HU_OFF_STATUS 8'h0C
`define HU_OFF_TXDATA 8'h10
`define HU_OFF_RXDATA 8'h14

// Control fields
`define HU_CTRL_HW_HS 0
`define HU_CTRL_SW_FLOW 1

// Status fields
`define HU_ST_TX_FULL 0
`define HU_ST_RX_AVAIL 1
`define HU_ST_BAUD_BUSY 2
`define HU_ST_OVERRUN 3
`define HU_ST_BAD_BAUD 4
`define HU_ST_FRAME_ERR 5
`define HU_ST_TX_PAUSED 6
`define HU_ST_TX_IDLE 7
`define HU_ST_HS_ADVISED 8

// Clock and baud figures
`define HU_CLK_PERIOD_NS 5
`define HU_CLK_HZ (1000000000 / `HU_CLK_PERIOD_NS)
`define HU_DEF_BAUD 32'h0001_C200
`define HU_MAX_BAUD 32'h004C_4B40
`define HU_MIN_BAUD 32'h0000_0FA0
`define HU_HS_ADVISE_BAUD 32'h000F_4240
`define HU_DEF_DIV ((`HU_CLK_HZ + (`HU_DEF_BAUD / 2)) / `HU_DEF_BAUD)

// Software flow characters and receive thresholds
`define HU_XON 8'h11
`define HU_XOFF 8'h13
`define HU_RX_HIGH 5'h0C
`define HU_RX_LOW 5'h04

`endif

// file: rtl/hu_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hu_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire pclk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] count
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_q];
	assign count = count_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage has no reset
	always @(posedge pclk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // hu_fifo
`default_nettype wire

// file: verif/hu_uart_checker.sv
// Port checker of the host UART
`timescale 1ns/1ps
`include "hu_uart_map.vh"
`default_nettype none
module hu_uart_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic host_tx_serial_in,
	input wire logic host_request_in,
	input wire logic host_rx_serial_out,
	input wire logic clear_to_host_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !por_n);
	logic hw_q;
	logic [31:0] baud_q;
	wire wr_done = pready && pwrite && !pslverr;
	// Baud seen by software, kept over presetn
	always @(posedge pclk or negedge por_n)
		if (!por_n)
			baud_q <= `HU_DEF_BAUD;
		else if (wr_done && paddr == `HU_OFF_BAUD && pwdata >= `HU_MIN_BAUD && pwdata <= `HU_MAX_BAUD)
			baud_q <= pwdata;
	always @(posedge pclk or negedge presetn or negedge por_n)
		if (!presetn || !por_n)
			hw_q <= 1'b0;
		else if (wr_done && paddr == `HU_OFF_CTRL)
			hw_q <= pwdata[`HU_CTRL_HW_HS];
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_unmapped: assert property (pready && paddr > `HU_OFF_RXDATA |-> pslverr)
		else $error("unmapped address accepted");
	a_low_width: assert property ($fell(host_rx_serial_out) |=> !host_rx_serial_out [*8])
		else $error("low bit too short");
	a_high_width: assert property ($rose(host_rx_serial_out) |=> host_rx_serial_out [*8])
		else $error("high bit too short");
	a_idle_release: assert property ($rose(presetn) |-> host_rx_serial_out && clear_to_host_out)
		else $error("lines not idle after reset");
	a_cts_hw_only: assert property (!clear_to_host_out |-> hw_q || $past(hw_q))
		else $error("clear-to-send low with handshake off");
	a_baud_read: assert property (pready && !pwrite && paddr == `HU_OFF_BAUD |-> prdata == baud_q)
		else $error("baud readback wrong");
	c_cts_low: cover property ($fell(clear_to_host_out));
	c_slverr: cover property (pslverr);
	c_tx_start: cover property ($fell(host_rx_serial_out));
endmodule // hu_uart_checker
bind hu_uart hu_uart_checker u_chk (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .host_tx_serial_in, .host_request_in, .host_rx_serial_out, .clear_to_host_out);
`default_nettype wire

// file: verif/hu_host_model.sv
// Host serial port model facing the UART
`timescale 1ns/1ps
`default_nettype none
module hu_host_model (
	input wire logic pclk,
	input wire logic host_rx_serial_out,
	input wire logic req_en,
	output logic host_tx_serial_in,
	output logic host_request_in
);
	int div = 1736;
	int frame_errs = 0;
	logic [7:0] rx_q[$];
	assign host_request_in = req_en;
	initial host_tx_serial_in = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			host_tx_serial_in <= f[i];
			repeat (div) @(posedge pclk);
		end
	endtask
	// Receiver sampling mid-bit
	always
	begin : rx_l
		logic [7:0] b;
		@(negedge host_rx_serial_out);
		repeat (div / 2) @(posedge pclk);
		if (host_rx_serial_out !== 1'b0)
			frame_errs++;
		repeat (8)
		begin
			repeat (div) @(posedge pclk);
			b = {host_rx_serial_out, b[7:1]};
		end
		repeat (div) @(posedge pclk);
		if (host_rx_serial_out !== 1'b1)
			frame_errs++;
		rx_q.push_back(b);
	end
endmodule // hu_host_model
`default_nettype wire

// file: verif/hu_uart_tb.sv
// Self-checking bench of the host UART
`timescale 1ns/1ps
`include "hu_uart_map.vh"
`default_nettype none
module hu_uart_tb;
	logic pclk, presetn, por_n, psel, penable, pwrite, req_en, er;
	logic [7:0] paddr, b;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, tx_in, rq_in, rx_out, cts;
	int err_count = 0, n_tests = 0, m_baud, t;
	logic [7:0] exp_q[$], rxe_q[$];
	hu_uart u_dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.host_tx_serial_in(tx_in), .host_request_in(rq_in), .host_rx_serial_out(rx_out), .clear_to_host_out(cts));
	hu_host_model u_host (.pclk, .host_rx_serial_out(rx_out), .req_en, .host_tx_serial_in(tx_in),
		.host_request_in(rq_in));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++t < 20000);
		if (pready !== 1'b1)
		begin
			err_count++;
			$display("unexpected pready expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(s, e, rd);
	endtask
	task automatic rbit(input int n, input logic e);
		apb(1'b0, `HU_OFF_STATUS, 32'h0000_0000);
		chk("status bit", 32'(e), 32'(rd[n]));
	endtask
	function automatic int m_div(input int bd);
		return (200000000 + bd / 2) / bd;
	endfunction
	task automatic tx_cmp(input int n);
		t = 0;
		while (u_host.rx_q.size() < n && t++ < 40000)
			@(posedge pclk);
		if (u_host.rx_q.size() < n)
		begin
			err_count++;
			$display("unexpected tx count expected %0d seen %0d", n, u_host.rx_q.size());
		end
		while (exp_q.size() > 0 && u_host.rx_q.size() > 0)
			chk("tx byte", 32'(exp_q.pop_front()), 32'(u_host.rx_q.pop_front()));
		exp_q.delete();
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge pclk);
		err_count++;
		results;
	end
	initial
	begin
		{psel, penable, pwrite, req_en, presetn, por_n} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		void'($urandom(83404));
		repeat (8) @(posedge pclk);
		{presetn, por_n} <= 2'b11;
		@(posedge pclk);
		m_baud = 115200;
		rchk("baud", `HU_OFF_BAUD, 32'(m_baud));
		rchk("div", `HU_OFF_DIV, 32'(m_div(m_baud)));
		rchk("ctrl", `HU_OFF_CTRL, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, 32'(er));
		chk("unmapped data", 32'h0000_0000, rd);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, `HU_OFF_BAUD, i ? 32'd5000001 : 32'd3999);
			rbit(`HU_ST_BAD_BAUD, 1'b1);
			rchk("baud kept", `HU_OFF_BAUD, 32'(m_baud));
			apb(1'b1, `HU_OFF_STATUS, 32'h0000_0010);
		end
		m_baud = 2000000 + $urandom % 3000001;
		apb(1'b1, `HU_OFF_BAUD, 32'(m_baud));
		repeat (40) @(posedge pclk);
		rchk("baud", `HU_OFF_BAUD, 32'(m_baud));
		rchk("div", `HU_OFF_DIV, 32'(m_div(m_baud)));
		rbit(`HU_ST_HS_ADVISED, 1'b1);
		u_host.div = m_div(m_baud);
		repeat (3)
		begin
			b = 8'($urandom);
			exp_q.push_back(b);
			apb(1'b1, `HU_OFF_TXDATA, 32'(b));
		end
		tx_cmp(3);
		apb(1'b1, `HU_OFF_CTRL, 32'h0000_0001);
		rbit(`HU_ST_HS_ADVISED, 1'b0);
		b = 8'($urandom);
		exp_q.push_back(b);
		apb(1'b1, `HU_OFF_TXDATA, 32'(b));
		repeat (30 * u_host.div) @(posedge pclk);
		chk("held tx", 32'h0000_0000, 32'(u_host.rx_q.size()));
		req_en <= 1'b1;
		tx_cmp(1);
		for (int i = 0; i < 17; i++)
		begin
			b = 8'($urandom);
			if (i < 16)
				exp_q.push_back(b);
			u_host.send_byte(b);
			chk("cts", 32'(i < 11), 32'(cts));
		end
		rbit(`HU_ST_OVERRUN, 1'b1);
		while (exp_q.size() > 0)
			rchk("rx byte", `HU_OFF_RXDATA, 32'(exp_q.pop_front()));
		rbit(`HU_ST_RX_AVAIL, 1'b0);
		chk("cts", 32'h0000_0001, 32'(cts));
		apb(1'b1, `HU_OFF_CTRL, 32'h0000_0002);
		u_host.send_byte(`HU_XOFF);
		rbit(`HU_ST_TX_PAUSED, 1'b1);
		rbit(`HU_ST_RX_AVAIL, 1'b0);
		u_host.send_byte(`HU_XON);
		rbit(`HU_ST_TX_PAUSED, 1'b0);
		for (int i = 0; i < 12; i++)
		begin
			b = 8'($urandom);
			if (b == `HU_XON || b == `HU_XOFF)
				b = b ^ 8'h01;
			rxe_q.push_back(b);
			u_host.send_byte(b);
		end
		exp_q.push_back(`HU_XOFF);
		tx_cmp(1);
		while (rxe_q.size() > 0)
			rchk("rx byte", `HU_OFF_RXDATA, 32'(rxe_q.pop_front()));
		exp_q.push_back(`HU_XON);
		tx_cmp(1);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk("baud", `HU_OFF_BAUD, 32'(m_baud));
		rchk("div", `HU_OFF_DIV, 32'(m_div(m_baud)));
		por_n <= 1'b0;
		repeat (8) @(posedge pclk);
		por_n <= 1'b1;
		@(posedge pclk);
		rchk("baud", `HU_OFF_BAUD, 32'd115200);
		chk("frame errors", 32'h0000_0000, 32'(u_host.frame_errs));
		results;
	end
endmodule // hu_uart_tb
`default_nettype wire
